// ---- hpp_params.svh ----
// constants for the host parallel port pin control block
// assumes one 50 MHz core clock and a synchronous active-high reset
`ifndef HPP_PARAMS_SVH
`define HPP_PARAMS_SVH
`define HPP_CLK_PERIOD_NS 20
`define HPP_DATA_W 16
`define HPP_ADDR_W 16
`define HPP_BYTE_W 8
`define HPP_BANK_SWITCH_CONTROL_REG_DATA_KEEP_BIT 0
`define HPP_BANK_SWITCH_CONTROL_REG_BYTE_KEEP_BIT 1
`define HPP_SEL_CTRL 2'h0
`define HPP_SEL_DATA_INC 2'h1
`define HPP_SEL_ADDR 2'h2
`define HPP_SEL_DATA 2'h3
`endif

// ---- hpp_pkg.sv ----
// types for the host parallel port pin control block
// assumes hpp_params.svh is included by the user of the constants
package hpp_pkg;
	typedef enum logic [1:0] {
		HPP_REG_CTRL,
		HPP_REG_ADDR,
		HPP_REG_DATA,
		HPP_REG_NONE
	} hpp_target_t;
	typedef enum {
		HPP_IDLE,
		HPP_FIRST,
		HPP_SECOND
	} hpp_state_t;
endpackage : hpp_pkg

// ---- hpp_pin_ctrl.sv ----
// host parallel port pin control: strap capture, tristate, keepers, pullups
// assumes synchronous pins; the pad ring resolves data from oe and keepers
// How it works
// - wide strap: sixteen address pins address memory
// - wide strap: sixteen data pins carry words
// - data pins shared between core and port
// - data pins float unless driving, reset, hold, off
// - data keepers hold last level, reset off
// - wide strap: byte lines become general IO
// - byte lines float unless driving or off
// - byte keepers hold last level, own bit
// - select lines pick one of three registers
// - byte marker orders word halves
// - pullups on only when enable strap low
// - enable strap caught at reset release only
// - wide mode drops control and address registers
`timescale 1ns/1ps
`include "hpp_params.svh"
module hpp_pin_ctrl
	import hpp_pkg::*;
#(
	parameter int DATA_W = `HPP_DATA_W,
	parameter int ADDR_W = `HPP_ADDR_W,
	parameter int BYTE_W = `HPP_BYTE_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// straps and global pin controls
	input wire logic port_enable_strap,
	input wire logic wide_mode_strap,
	input wire logic bus_hold,
	input wire logic output_float_n,
	// bank switch control register bits
	input wire logic bank_switch_control_reg_wr,
	input wire logic [1:0] bank_switch_control_reg_wdata,
	// host control pins
	input wire logic port_chip_select_n,
	input wire logic register_select_low,
	input wire logic register_select_high,
	input wire logic byte_half_marker,
	input wire logic host_write,
	input wire logic host_strobe,
	// host byte lines
	input wire logic [BYTE_W-1:0] host_byte_lines_in,
	output logic [BYTE_W-1:0] host_byte_lines_out,
	output logic host_byte_lines_oe,
	output logic byte_line_keeper_enable,
	// general purpose use of byte lines in wide mode
	input wire logic [BYTE_W-1:0] gpio_out,
	input wire logic [BYTE_W-1:0] gpio_dir,
	output logic [BYTE_W-1:0] gpio_in,
	// wide address and data pins
	input wire logic [ADDR_W-1:0] wide_address_lines,
	input wire logic [DATA_W-1:0] wide_data_lines_in,
	output logic [DATA_W-1:0] wide_data_lines_out,
	output logic wide_data_lines_oe,
	output logic data_keeper_enable,
	// core external bus use of the data pins
	input wire logic core_drive,
	input wire logic [DATA_W-1:0] core_wdata,
	// memory side of the port
	input wire logic [DATA_W-1:0] mem_rdata,
	output logic mem_req,
	output logic mem_we,
	output logic [ADDR_W-1:0] mem_addr,
	output logic [DATA_W-1:0] mem_wdata,
	output logic [1:0] acc_target,
	// status
	output logic port_enabled,
	output logic wide_mode,
	output logic pullup_enable
);
	logic port_en_r;
	logic wide_r;
	logic rst_d_r;
	logic keep_d_r;
	logic keep_b_r;
	logic [ADDR_W-1:0] addr_r;
	logic [BYTE_W-1:0] lo_byte_r;
	logic [DATA_W-1:0] rd_word_r;
	logic rd_valid_r;
	logic access;
	logic drive_word;
	logic drive_bytes;
	logic [1:0] sel;
	hpp_target_t tgt;
	hpp_target_t wide_tgt;

	function automatic hpp_target_t hpp_decode(input logic [1:0] s,
			input logic wide);
		hpp_target_t t;
		t = HPP_REG_DATA;
		if (wide) begin
			t = HPP_REG_DATA; // wide mode has no ctrl or addr reg
		end else if (s == `HPP_SEL_CTRL) begin
			t = HPP_REG_CTRL;
		end else if (s == `HPP_SEL_ADDR) begin
			t = HPP_REG_ADDR;
		end
		return t;
	endfunction : hpp_decode

	assign sel = {register_select_high, register_select_low};
	// disabled port or deselected chip sees nothing
	assign access = port_en_r && !port_chip_select_n && host_strobe;
	assign tgt = hpp_decode(sel, 1'b0);
	assign wide_tgt = hpp_decode(sel, 1'b1);

	// strap taken only on the first clock after reset release
	always_ff @(posedge clk) begin
		rst_d_r <= rst;
		if (rst) begin
			port_en_r <= 1'b0;
			wide_r <= 1'b0;
		end else if (rst_d_r) begin
			port_en_r <= port_enable_strap;
			wide_r <= wide_mode_strap;
		end
	end

	// keeper bits of the bank switch control register, off after reset
	always_ff @(posedge clk) begin
		if (rst) begin
			keep_d_r <= 1'b0;
			keep_b_r <= 1'b0;
		end else if (bank_switch_control_reg_wr) begin
			keep_d_r <= bank_switch_control_reg_wdata[`HPP_BANK_SWITCH_CONTROL_REG_DATA_KEEP_BIT];
			keep_b_r <= bank_switch_control_reg_wdata[`HPP_BANK_SWITCH_CONTROL_REG_BYTE_KEEP_BIT];
		end
	end

	// host access handling: byte pairing or wide words
	always_ff @(posedge clk) begin
		if (rst) begin
			addr_r <= '0;
			lo_byte_r <= '0;
			rd_word_r <= '0;
			rd_valid_r <= 1'b0;
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= '0;
			mem_wdata <= '0;
			acc_target <= 2'h0;
		end else begin
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			rd_valid_r <= 1'b0;
			if (access && wide_r) begin
				// full word over the wide pins
				mem_req <= 1'b1;
				mem_we <= host_write;
				mem_addr <= wide_address_lines;
				mem_wdata <= wide_data_lines_in;
				acc_target <= wide_tgt;
				rd_word_r <= mem_rdata;
				rd_valid_r <= !host_write;
			end else if (access) begin
				acc_target <= tgt;
				if (!byte_half_marker) begin
					// first byte is the high half
					lo_byte_r <= host_byte_lines_in;
					rd_word_r <= mem_rdata;
					rd_valid_r <= !host_write;
				end else if (tgt == HPP_REG_ADDR && host_write) begin
					addr_r <= {lo_byte_r, host_byte_lines_in};
				end else if (tgt == HPP_REG_DATA) begin
					// second byte completes the word
					mem_req <= 1'b1;
					mem_we <= host_write;
					mem_addr <= addr_r;
					mem_wdata <= {lo_byte_r, host_byte_lines_in};
					rd_valid_r <= !host_write;
				end
			end
		end
	end

	// pin drive: the core bus wins, the port only when granted
	assign drive_word = core_drive || (port_en_r && wide_r && rd_valid_r);
	assign drive_bytes = port_en_r && (wide_r ? (|gpio_dir) : rd_valid_r);

	always_ff @(posedge clk) begin
		if (rst || bus_hold || !output_float_n) begin
			wide_data_lines_oe <= 1'b0;
			wide_data_lines_out <= '0;
		end else begin
			wide_data_lines_oe <= drive_word;
			wide_data_lines_out <= core_drive ? core_wdata : rd_word_r;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || !output_float_n) begin
			host_byte_lines_oe <= 1'b0;
			host_byte_lines_out <= '0;
		end else begin
			host_byte_lines_oe <= drive_bytes;
			if (wide_r) begin
				host_byte_lines_out <= gpio_out;
			end else if (byte_half_marker) begin
				host_byte_lines_out <= rd_word_r[BYTE_W-1:0];
			end else begin
				host_byte_lines_out <= rd_word_r[DATA_W-1:BYTE_W];
			end
		end
	end

	// status and pin control outputs, all registered
	always_ff @(posedge clk) begin
		if (rst) begin
			port_enabled <= 1'b0;
			wide_mode <= 1'b0;
			pullup_enable <= 1'b0;
			gpio_in <= '0;
			data_keeper_enable <= 1'b0;
			byte_line_keeper_enable <= 1'b0;
		end else begin
			port_enabled <= port_en_r;
			wide_mode <= wide_r;
			// off until the strap has really been taken
			pullup_enable <= !port_en_r && !rst_d_r;
			gpio_in <= wide_r ? host_byte_lines_in : '0;
			data_keeper_enable <= keep_d_r;
			byte_line_keeper_enable <= keep_b_r;
		end
	end

	a_float_data_off: assert property (
		@(posedge clk) disable iff (rst)
		(!output_float_n || bus_hold) |=> !wide_data_lines_oe)
		else $error("data pins driven while float or hold");
	a_float_bytes_off: assert property (
		@(posedge clk) disable iff (rst)
		!output_float_n |=> !host_byte_lines_oe)
		else $error("byte lines driven while float");
	a_keep_reset_off: assert property (
		@(posedge clk)
		$fell(rst) |-> !data_keeper_enable && !byte_line_keeper_enable)
		else $error("keepers enabled out of reset");
	a_keep_follow_bit: assert property (
		@(posedge clk) disable iff (rst)
		bank_switch_control_reg_wr |=> ##1 byte_line_keeper_enable ==
			$past(bank_switch_control_reg_wdata[1], 2))
		else $error("byte keeper ignores control bit");
	a_pullup_strap: assert property (
		@(posedge clk) disable iff (rst)
		pullup_enable |-> !port_enabled)
		else $error("pullups on while port enabled");
	a_strap_sticky: assert property (
		@(posedge clk) disable iff (rst)
		$past(rst_d_r) == 1'b0 && !$past(rst) |-> $stable(port_en_r))
		else $error("enable strap changed outside reset");
	a_cs_ignored: assert property (
		@(posedge clk) disable iff (rst)
		port_chip_select_n |=> !mem_req)
		else $error("transfer started without chip select");
	a_disabled_quiet: assert property (
		@(posedge clk) disable iff (rst)
		!port_en_r && !core_drive |=> !wide_data_lines_oe &&
			!host_byte_lines_oe)
		else $error("disabled port drives pins");
	a_wide_word: assert property (
		@(posedge clk) disable iff (rst)
		access && wide_r |=> mem_req && mem_addr == $past(wide_address_lines))
		else $error("wide access lost its address");
endmodule : hpp_pin_ctrl

// ---- hpp_host_model.sv ----
// host side model: drives the port pins for one access at a time
// assumes the bench clock; pins change on the falling edge
`timescale 1ns/1ps
module hpp_host_model (
	// clock
	input wire logic clk,
	// host pins
	output logic port_chip_select_n,
	output logic register_select_low,
	output logic register_select_high,
	output logic byte_half_marker,
	output logic host_write,
	output logic host_strobe,
	output logic [7:0] host_byte_lines_in,
	output logic [15:0] wide_address_lines,
	output logic [15:0] wide_data_lines_in
);
	initial begin
		port_chip_select_n = 1'h1;
		{register_select_high, register_select_low} = 2'h0;
		byte_half_marker = 1'h0;
		host_write = 1'h0;
		host_strobe = 1'h0;
		host_byte_lines_in = 8'h00;
		wide_address_lines = 16'h0000;
		wide_data_lines_in = 16'h0000;
	end
	// select, marker and data held for the whole access
	task acc(input logic [1:0] sel, input logic mk, input logic wr,
		input logic [15:0] a, input logic [15:0] d, input logic cs_n);
		@(negedge clk);
		port_chip_select_n = cs_n;
		{register_select_high, register_select_low} = sel;
		byte_half_marker = mk;
		host_write = wr;
		host_strobe = 1'h1;
		host_byte_lines_in = d[7:0];
		wide_address_lines = a;
		wide_data_lines_in = d;
		@(negedge clk);
		port_chip_select_n = 1'h1;
		host_strobe = 1'h0;
		// released lines invert so a stale value cannot pass
		host_byte_lines_in = ~d[7:0];
		wide_data_lines_in = ~d;
	endtask : acc
endmodule : hpp_host_model

// ---- hpp_pin_ctrl_tb.sv ----
// self-checking bench for the host parallel port pin control block
// assumes the host model drives the host pins; memory data is constant
`timescale 1ns/1ps
`include "hpp_params.svh"
module hpp_pin_ctrl_tb;
	// set at declaration so no clock edge is seen at time zero
	logic clk = 1'h0;
	logic rst, port_enable_strap, wide_mode_strap, bus_hold;
	logic output_float_n, bank_switch_control_reg_wr, core_drive, mem_req, mem_we;
	logic port_chip_select_n, register_select_low, register_select_high;
	logic byte_half_marker, host_write, host_strobe, host_byte_lines_oe;
	logic byte_line_keeper_enable, wide_data_lines_oe, data_keeper_enable;
	logic port_enabled, wide_mode, pullup_enable;
	logic [1:0] bank_switch_control_reg_wdata, acc_target;
	logic [7:0] host_byte_lines_in, host_byte_lines_out;
	logic [7:0] gpio_out, gpio_dir, gpio_in;
	logic [15:0] wide_address_lines, wide_data_lines_in, wide_data_lines_out;
	logic [15:0] core_wdata, mem_addr, mem_wdata;
	logic [15:0] mem_rdata = 16'h5a3c;
	int num_errors = 0;
	int total_checks = 0;
	hpp_host_model h (.clk, .port_chip_select_n, .register_select_low,
		.register_select_high, .byte_half_marker, .host_write,
		.host_strobe, .host_byte_lines_in, .wide_address_lines,
		.wide_data_lines_in);
	hpp_pin_ctrl dut (.clk, .rst, .port_enable_strap, .wide_mode_strap,
		.bus_hold, .output_float_n, .bank_switch_control_reg_wr, .bank_switch_control_reg_wdata,
		.port_chip_select_n, .register_select_low, .register_select_high,
		.byte_half_marker, .host_write, .host_strobe, .host_byte_lines_in,
		.host_byte_lines_out, .host_byte_lines_oe, .byte_line_keeper_enable,
		.gpio_out, .gpio_dir, .gpio_in, .wide_address_lines,
		.wide_data_lines_in, .wide_data_lines_out, .wide_data_lines_oe,
		.data_keeper_enable, .core_drive, .core_wdata, .mem_rdata, .mem_req,
		.mem_we, .mem_addr, .mem_wdata, .acc_target, .port_enabled,
		.wide_mode, .pullup_enable);
	initial begin
		forever #10 clk = ~clk;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick
	task do_reset(input logic en, input logic wide);
		rst = 1'h1;
		port_enable_strap = en;
		wide_mode_strap = wide;
		tick(2);
		rst = 1'h0;
		tick(3);
		// strap moves after release and must be ignored
		port_enable_strap = ~en;
	endtask : do_reset
	task wrap_up;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	initial begin
		#(20 * 600);
		num_errors++;
		wrap_up();
	end
	initial begin
		{bus_hold, bank_switch_control_reg_wr, core_drive, bank_switch_control_reg_wdata} = 5'h00;
		{gpio_out, gpio_dir, core_wdata} = 32'h0;
		output_float_n = 1'h1;
		do_reset(1'h1, 1'h1);
		chk(data_keeper_enable, 1'h0);
		chk(byte_line_keeper_enable, 1'h0);
		chk({port_enabled, wide_mode}, 2'h3);
		chk(pullup_enable, 1'h0);
		h.acc(`HPP_SEL_DATA, 1'h0, 1'h1, 16'h1234, 16'hbeef, 1'h0);
		// request pulse stands for one cycle only: look at once
		chk({mem_req, mem_we}, 2'h3);
		chk(mem_addr, 16'h1234);
		chk(mem_wdata, 16'hbeef);
		// no control register in wide mode: still a data access
		h.acc(`HPP_SEL_CTRL, 1'h0, 1'h0, 16'h0042, 16'h0000, 1'h0);
		chk(acc_target, hpp_pkg::HPP_REG_DATA);
		tick(1);
		chk({wide_data_lines_oe, wide_data_lines_out}, 17'h15a3c);
		tick(1);
		chk(wide_data_lines_oe, 1'h0);
		for (int i = 0; i < 2; i++) begin
			{bus_hold, output_float_n} = (i == 0) ? 2'h3 : 2'h0;
			h.acc(`HPP_SEL_DATA, 1'h0, 1'h0, 16'h0042, 16'h0000, 1'h0);
			tick(1);
			chk(wide_data_lines_oe, 1'h0);
		end
		{bus_hold, output_float_n} = 2'h1;
		core_drive = 1'h1;
		core_wdata = 16'hc0de;
		tick(2);
		chk({wide_data_lines_oe, wide_data_lines_out}, 17'h1c0de);
		core_drive = 1'h0;
		h.acc(`HPP_SEL_DATA, 1'h0, 1'h1, 16'h0001, 16'h00f0, 1'h1);
		chk(mem_req, 1'h0);
		for (int i = 3; i >= 2; i--) begin
			bank_switch_control_reg_wr = 1'h1;
			bank_switch_control_reg_wdata = i[1:0];
			tick(1);
			bank_switch_control_reg_wr = 1'h0;
			tick(1);
			chk(byte_line_keeper_enable, i[1]);
			chk(data_keeper_enable, i[0]);
		end
		gpio_dir = 8'hff;
		gpio_out = 8'ha5;
		tick(2);
		chk({host_byte_lines_oe, host_byte_lines_out}, 9'h1a5);
		chk(gpio_in, 8'h0f);
		output_float_n = 1'h0;
		tick(2);
		chk(host_byte_lines_oe, 1'h0);
		output_float_n = 1'h1;
		gpio_dir = 8'h00;
		do_reset(1'h1, 1'h0);
		chk(wide_mode, 1'h0);
		h.acc(`HPP_SEL_ADDR, 1'h0, 1'h1, 16'h0, 16'h0012, 1'h0);
		h.acc(`HPP_SEL_ADDR, 1'h1, 1'h1, 16'h0, 16'h0034, 1'h0);
		h.acc(`HPP_SEL_DATA, 1'h0, 1'h1, 16'h0, 16'h00ab, 1'h0);
		h.acc(`HPP_SEL_DATA, 1'h1, 1'h1, 16'h0, 16'h00cd, 1'h0);
		chk({mem_req, mem_addr}, 17'h11234);
		chk(mem_wdata, 16'habcd);
		// byte reads: high half first, then the low half
		h.acc(`HPP_SEL_DATA, 1'h0, 1'h0, 16'h0, 16'h0000, 1'h0);
		tick(1);
		chk({host_byte_lines_oe, host_byte_lines_out}, 9'h15a);
		h.acc(`HPP_SEL_DATA, 1'h1, 1'h0, 16'h0, 16'h0000, 1'h0);
		tick(1);
		chk({host_byte_lines_oe, host_byte_lines_out}, 9'h13c);
		do_reset(1'h0, 1'h1);
		chk({port_enabled, pullup_enable}, 2'h1);
		h.acc(`HPP_SEL_DATA, 1'h0, 1'h0, 16'h0042, 16'h0000, 1'h0);
		chk(mem_req, 1'h0);
		tick(1);
		chk(wide_data_lines_oe, 1'h0);
		wrap_up();
	end
endmodule : hpp_pin_ctrl_tb
